//--- logic/i2cnv_regs.svh
`ifndef I2CNV_REGS_SVH
`define I2CNV_REGS_SVH

// Control-register slave map
`define I2CNV_CTL_MEMCTL 8'h00
`define I2CNV_CTL_SN_FIRST 8'h01
`define I2CNV_CTL_SN_LAST 8'h08
`define I2CNV_CTL_ID_FIRST 8'h09
`define I2CNV_CTL_LAST_RD 8'h0C
`define I2CNV_CTL_CMD 8'hAA

// Reset values
`define I2CNV_MEMCTL_RST 8'h00
`define I2CNV_SERIAL_RST 64'h0000_0000_0000_0000

// Bit counter positions inside one nine-clock byte slot
`define I2CNV_BIT_LAST 4'h7
`define I2CNV_BIT_ACK 4'h8

// Block-protect field codes
`define I2CNV_PROT_NONE 2'h0
`define I2CNV_PROT_QUARTER 2'h1
`define I2CNV_PROT_HALF 2'h2

`endif

//--- logic/i2cnv_pkg.sv
package i2cnv_pkg;

  // Link sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    I2CNV_IDLE = 3'h0,
    I2CNV_DEV = 3'h1,
    I2CNV_ADDR_HI = 3'h3,
    I2CNV_ADDR_LO = 3'h2,
    I2CNV_WDATA = 3'h6,
    I2CNV_RDATA = 3'h7,
    I2CNV_IGNORE = 3'h5
  } i2cnv_state_t;

  // Memory control register layout
  typedef struct packed {
    logic [3:0] spare_hi;
    logic [1:0] protect;
    logic spare_lo;
    logic serial_lock_bit;
  } i2cnv_ctl_t;

endpackage

//--- logic/i2cnv_cdc_word.sv
`timescale 1ns/100ps
// Moves a word from the link clock to the system clock by toggle handshake
module i2cnv_cdc_word #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic rst,
  input wire logic src_load,
  input wire logic [W-1:0] src_data,
  input wire logic dst_clk,
  output logic [W-1:0] dst_data
);

  logic [W-1:0] hold_reg;
  logic tgl_reg;
  logic meta_reg;
  logic sync_reg;
  logic seen_reg;

  // Source side holds the word steady while the toggle travels
  always_ff @(posedge src_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= '0;
      tgl_reg <= 1'b0;
    end else if (src_load) begin
      hold_reg <= src_data;
      tgl_reg <= ~tgl_reg;
    end
  end

  // Three flops on the toggle, only the second and third are compared
  always_ff @(posedge dst_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      meta_reg <= tgl_reg;
      sync_reg <= meta_reg;
      seen_reg <= sync_reg;
    end
  end

  wire capture = sync_reg ^ seen_reg;

  // Word is stable by the time the toggle has passed both flops
  always_ff @(posedge dst_clk or posedge rst) begin
    if (rst) begin
      dst_data <= '0;
    end else if (capture) begin
      dst_data <= hold_reg;
    end
  end

endmodule

//--- logic/i2cnv_slave.sv
`timescale 1ns/100ps
// Overview of operation
// - Read bit set: drive SDA after address
// - Current read starts at following location
// - Memory counter increments, wraps to zero
// - Control burst read wraps to zero
// - Write runs until STOP, START or NACK
// - Commit after eight bits, ACK each
// - Protected byte: NACK, counter holds
// - Random read loads counter from address
// - Control write stops at last writable
// - Non-writable location: NACK, ignore rest
// - Command write: counter to zero
// - Out-of-bound address: NACK, counter holds
// - Locked serial: only zero and command
// - Command location unread, wraps to zero
// - Out-of-bound random read address NACKed
// - Eight-byte serial store, zero default
// - Serial bytes at locations one to eight
// - Write-protect pin blocks all writes
// - After NACK ignore until STOP/START
// - Unknown command ACKed, address to zero
`include "i2cnv_regs.svh"
module i2cnv_slave #(
  parameter int ADDR_W = 13,
  parameter logic [6:0] MEM_SLV = 7'h50, // Arbitrary value
  parameter logic [6:0] CTL_SLV = 7'h18, // Arbitrary value
  parameter logic [31:0] DEV_ID = 32'h1234_5678 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic wp,
  output logic [7:0] ctl_status,
  output logic serial_lock_bit
);

  localparam int DEPTH = 1 << ADDR_W;

  logic [7:0] mem_array [DEPTH];
  logic start_tgl_reg;
  logic stop_tgl_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  i2cnv_pkg::i2cnv_state_t state_reg;
  i2cnv_pkg::i2cnv_state_t state_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic sel_ctl_reg;
  logic rw_reg;
  logic ack_reg;
  logic ack_next;
  logic [ADDR_W-1:0] mem_ptr_reg;
  logic [7:0] ctl_ptr_reg;
  logic [ADDR_W-9:0] addr_hi_reg;
  i2cnv_pkg::i2cnv_ctl_t memctl_reg;
  logic [63:0] serial_reg;
  logic wp_meta_reg;
  logic wp_sync_reg;
  logic [7:0] status_sys;

  // Serial byte n sits at bits 8*(n-1)
  function automatic int sn_lsb(input logic [7:0] a);
    sn_lsb = (int'(a) - 1) * 8;
  endfunction

  // Upper quarter, upper half or whole array under block protect
  function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] p);
    case (p)
      `I2CNV_PROT_NONE: is_protected = 1'b0;
      `I2CNV_PROT_QUARTER: is_protected = &a[ADDR_W-1 -: 2];
      `I2CNV_PROT_HALF: is_protected = a[ADDR_W-1];
      default: is_protected = 1'b1;
    endcase
  endfunction

  // Readable control locations, command register excluded
  function automatic logic [7:0] ctl_read(input logic [7:0] a);
    if (a == `I2CNV_CTL_MEMCTL) begin
      ctl_read = memctl_reg;
    end else if (a <= `I2CNV_CTL_SN_LAST) begin
      ctl_read = serial_reg[sn_lsb(a) +: 8];
    end else begin
      ctl_read = DEV_ID[8 * (int'(`I2CNV_CTL_LAST_RD) - int'(a)) +: 8];
    end
  endfunction

  // Start and stop are seen on SDA edges while SCL is high; toggles keep
  // them as events so the SCL side can notice them on its next edge
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tgl_reg <= 1'b0;
    end else if (scl) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  always_ff @(posedge sda_in or posedge rst) begin
    if (rst) begin
      stop_tgl_reg <= 1'b0;
    end else if (scl) begin
      stop_tgl_reg <= ~stop_tgl_reg;
    end
  end

  wire start_hit = start_tgl_reg ^ start_seen_reg;
  wire stop_hit = stop_tgl_reg ^ stop_seen_reg;

  // Byte framing and decode
  wire [7:0] byte_in = {rx_reg[6:0], sda_in};
  wire at_byte_end = bit_cnt_reg == `I2CNV_BIT_LAST;
  wire at_ack_clk = bit_cnt_reg == `I2CNV_BIT_ACK;
  wire match_mem = byte_in[7:1] == MEM_SLV;
  wire match_ctl = byte_in[7:1] == CTL_SLV;
  wire [ADDR_W-1:0] mem_addr_in = {addr_hi_reg, byte_in};
  wire ctl_addr_ok = byte_in <= `I2CNV_CTL_LAST_RD || byte_in == `I2CNV_CTL_CMD;

  // Write permission for the location under the counter
  wire ctl_at_zero = ctl_ptr_reg == `I2CNV_CTL_MEMCTL;
  wire ctl_at_cmd = ctl_ptr_reg == `I2CNV_CTL_CMD;
  wire ctl_at_sn = ctl_ptr_reg >= `I2CNV_CTL_SN_FIRST && ctl_ptr_reg <= `I2CNV_CTL_SN_LAST;
  wire sn_open = ctl_at_sn && !memctl_reg.serial_lock_bit;
  wire ctl_wr_ok = ctl_at_zero || ctl_at_cmd || sn_open;
  wire mem_wr_ok = !is_protected(mem_ptr_reg, memctl_reg.protect);
  wire wr_ok = !wp_sync_reg && (sel_ctl_reg ? ctl_wr_ok : mem_wr_ok);
  // A frame edge on this clock means the byte was cut short, so nothing commits
  wire frame_quiet = !start_hit && !stop_hit;
  wire data_taken = state_reg == i2cnv_pkg::I2CNV_WDATA && at_byte_end && wr_ok && frame_quiet;
  wire mem_we = data_taken && !sel_ctl_reg;

  // Read side: command or unknown location reads from zero
  wire ctl_rd_wrap = ctl_at_cmd || ctl_ptr_reg > `I2CNV_CTL_LAST_RD;
  wire [7:0] ctl_rd_addr = ctl_rd_wrap ? `I2CNV_CTL_MEMCTL : ctl_ptr_reg;
  wire ctl_rd_last = ctl_rd_addr == `I2CNV_CTL_LAST_RD;
  wire [7:0] ctl_rd_next = ctl_rd_last ? `I2CNV_CTL_MEMCTL : ctl_rd_addr + 8'h01;
  wire [7:0] rd_byte = sel_ctl_reg ? ctl_read(ctl_rd_addr) : mem_array[mem_ptr_reg];
  wire enter_rd = at_ack_clk && ack_reg && rw_reg && state_reg == i2cnv_pkg::I2CNV_DEV;
  wire more_rd = at_ack_clk && !sda_in && state_reg == i2cnv_pkg::I2CNV_RDATA;
  wire load_tx = enter_rd || more_rd;

  // Sequencer: what follows the ACK slot of each byte
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      i2cnv_pkg::I2CNV_DEV: begin
        if (at_ack_clk) begin
          if (!ack_reg) begin
            state_next = i2cnv_pkg::I2CNV_IDLE;
          end else if (rw_reg) begin
            state_next = i2cnv_pkg::I2CNV_RDATA;
          end else if (sel_ctl_reg) begin
            state_next = i2cnv_pkg::I2CNV_ADDR_LO;
          end else begin
            state_next = i2cnv_pkg::I2CNV_ADDR_HI;
          end
        end
      end
      i2cnv_pkg::I2CNV_ADDR_HI: begin
        if (at_ack_clk) begin
          state_next = i2cnv_pkg::I2CNV_ADDR_LO;
        end
      end
      i2cnv_pkg::I2CNV_ADDR_LO, i2cnv_pkg::I2CNV_WDATA: begin
        if (at_ack_clk) begin
          state_next = ack_reg ? i2cnv_pkg::I2CNV_WDATA : i2cnv_pkg::I2CNV_IGNORE;
        end
      end
      i2cnv_pkg::I2CNV_RDATA: begin
        if (at_ack_clk && sda_in) begin
          state_next = i2cnv_pkg::I2CNV_IGNORE;
        end
      end
      default: state_next = state_reg;
    endcase
  end

  // ACK decision taken on the eighth bit of each byte
  always_comb begin
    case (state_reg)
      i2cnv_pkg::I2CNV_DEV: ack_next = match_mem || match_ctl;
      i2cnv_pkg::I2CNV_ADDR_HI: ack_next = 1'b1;
      i2cnv_pkg::I2CNV_ADDR_LO: ack_next = !sel_ctl_reg || ctl_addr_ok;
      i2cnv_pkg::I2CNV_WDATA: ack_next = wr_ok;
      default: ack_next = 1'b0;
    endcase
  end

  // A start overrides everything; its first data bit is this edge's bit
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
      state_reg <= i2cnv_pkg::I2CNV_IDLE;
      bit_cnt_reg <= 4'h0;
    end else begin
      start_seen_reg <= start_tgl_reg;
      stop_seen_reg <= stop_tgl_reg;
      if (start_hit) begin
        state_reg <= i2cnv_pkg::I2CNV_DEV;
        bit_cnt_reg <= 4'h1;
      end else if (stop_hit) begin
        state_reg <= i2cnv_pkg::I2CNV_IDLE;
        bit_cnt_reg <= 4'h1;
      end else begin
        state_reg <= state_next;
        bit_cnt_reg <= at_ack_clk ? 4'h0 : bit_cnt_reg + 4'h1;
      end
    end
  end

  // Shift register, slave select and ACK flag
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      rx_reg <= 8'h00;
      ack_reg <= 1'b0;
      sel_ctl_reg <= 1'b0;
      rw_reg <= 1'b0;
    end else begin
      rx_reg <= start_hit ? {7'h00, sda_in} : byte_in;
      if (start_hit) begin
        ack_reg <= 1'b0;
      end else if (at_byte_end) begin
        ack_reg <= ack_next;
      end
      if (at_byte_end && state_reg == i2cnv_pkg::I2CNV_DEV && !start_hit) begin
        sel_ctl_reg <= match_ctl;
        rw_reg <= byte_in[0];
      end
    end
  end

  // Address counters, control registers and serial store
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      mem_ptr_reg <= '0;
      ctl_ptr_reg <= `I2CNV_CTL_MEMCTL;
      addr_hi_reg <= '0;
      memctl_reg <= `I2CNV_MEMCTL_RST;
      serial_reg <= `I2CNV_SERIAL_RST;
      tx_reg <= 8'h00;
    end else if (!start_hit && !stop_hit) begin
      if (at_byte_end && state_reg == i2cnv_pkg::I2CNV_ADDR_HI) begin
        addr_hi_reg <= byte_in[ADDR_W-9:0];
      end
      if (at_byte_end && state_reg == i2cnv_pkg::I2CNV_ADDR_LO) begin
        if (!sel_ctl_reg) begin
          mem_ptr_reg <= mem_addr_in;
        end else if (ctl_addr_ok) begin
          ctl_ptr_reg <= byte_in;
        end
      end
      if (mem_we) begin
        mem_ptr_reg <= mem_ptr_reg + ADDR_W'(1);
      end
      if (data_taken && sel_ctl_reg) begin
        if (ctl_at_cmd) begin
          ctl_ptr_reg <= `I2CNV_CTL_MEMCTL;
        end else begin
          ctl_ptr_reg <= ctl_ptr_reg + 8'h01;
          if (ctl_at_zero) begin
            memctl_reg <= byte_in;
          end else begin
            serial_reg[sn_lsb(ctl_ptr_reg) +: 8] <= byte_in;
          end
        end
      end
      if (load_tx) begin
        tx_reg <= rd_byte;
        if (sel_ctl_reg) begin
          ctl_ptr_reg <= ctl_rd_next;
        end else begin
          mem_ptr_reg <= mem_ptr_reg + ADDR_W'(1);
        end
      end
    end
  end

  // Array is plain SRAM, so it has no reset
  always_ff @(posedge scl) begin
    if (mem_we && !start_hit && !stop_hit) begin
      mem_array[mem_ptr_reg] <= byte_in;
    end
  end

  // Write-protect pin only changes the next byte decision, two SCL flops suffice
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      wp_meta_reg <= 1'b0;
      wp_sync_reg <= 1'b0;
    end else begin
      wp_meta_reg <= wp;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  // SDA is changed only while SCL is low
  wire ack_slot = at_ack_clk && ack_reg && state_reg != i2cnv_pkg::I2CNV_RDATA;
  wire [2:0] tx_idx = 3'(4'h7 - bit_cnt_reg);
  wire rd_slot = state_reg == i2cnv_pkg::I2CNV_RDATA && bit_cnt_reg <= `I2CNV_BIT_LAST;
  wire drive_low = ack_slot || (rd_slot && !tx_reg[tx_idx]);

  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      sda_oe_n <= ~drive_low;
      sda_out <= 1'b0;
    end
  end

  // Control register state mirrored into the system clock
  i2cnv_cdc_word #(
    .W(8)
  ) u_status_cdc (
    .src_clk(scl),
    .rst(rst),
    .src_load(data_taken && sel_ctl_reg && ctl_at_zero),
    .src_data(byte_in),
    .dst_clk(clk_sys),
    .dst_data(status_sys)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_status <= `I2CNV_MEMCTL_RST;
      serial_lock_bit <= 1'b0;
    end else begin
      ctl_status <= status_sys;
      serial_lock_bit <= status_sys[0];
    end
  end

endmodule

//--- sim/i2cnv_slave_monitor.sv
`timescale 1ns/100ps
// Pin checker; link checks rebuild the bit slot from SCL and SDA
module i2cnv_slave_monitor #(
  parameter logic [6:0] MEM_SLV = 7'h50,
  parameter logic [6:0] CTL_SLV = 7'h18
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic wp,
  input wire logic [7:0] ctl_status,
  input wire logic serial_lock_bit
);
  logic st_tgl, seen, rw, mem;
  logic [3:0] cnt;
  logic [1:0] nb;
  logic [7:0] sh;
  wire fresh = st_tgl != seen;
  wire [3:0] k = fresh ? 4'h0 : cnt;
  wire [1:0] b = fresh ? 2'h0 : nb;
  wire ack_clk = k == 4'h8;
  wire own = sh[7:1] == MEM_SLV || sh[7:1] == CTL_SLV;
  wire data_slot = !rw && (mem ? b == 2'h3 : b[1]);
  // A START flips a toggle; the SCL side sees it as a restart, no shared flop
  always_ff @(negedge sda_in or posedge rst)
    if (rst) st_tgl <= 1'b0;
    else if (scl) st_tgl <= ~st_tgl;
  // Bit and byte position, byte count saturating at the fourth byte, the first memory data byte
  always_ff @(posedge scl or posedge rst)
    if (rst) begin
      {seen, cnt, nb, sh, rw, mem} <= '0;
    end else begin
      seen <= st_tgl;
      sh <= {sh[6:0], sda_in};
      cnt <= ack_clk ? 4'h0 : k + 4'h1;
      nb <= ack_clk && b != 2'h3 ? b + 2'h1 : b;
      if (ack_clk && b == 2'h0) begin
        rw <= sh[0];
        mem <= sh[7:1] == MEM_SLV;
      end
    end
  a_sda_out_low: assert property (@(posedge clk_sys) disable iff (rst) !sda_out)
    else $error("sda_out high");
  a_lock_mirror: assert property (@(posedge clk_sys) disable iff (rst)
    serial_lock_bit == ctl_status[0]) else $error("lock mismatch");
  a_status_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    scl [*8] |-> $stable(ctl_status)) else $error("status moved");
  a_idle_free: assert property (@(posedge clk_sys) disable iff (rst)
    scl [*8] |-> sda_oe_n) else $error("idle sda held");
  a_master_bits: assert property (@(posedge scl) disable iff (rst)
    (b == 2'h0 || !rw) && !ack_clk |-> sda_oe_n) else $error("master bit driven");
  a_own_ack: assert property (@(posedge scl) disable iff (rst)
    b == 2'h0 && ack_clk && own |-> !sda_oe_n) else $error("no address ack");
  a_foreign_nack: assert property (@(posedge scl) disable iff (rst)
    b == 2'h0 && ack_clk && !own |-> sda_oe_n) else $error("foreign ack");
  a_read_ack_free: assert property (@(posedge scl) disable iff (rst)
    rw && b != 2'h0 && ack_clk |-> sda_oe_n) else $error("ack slot driven");
  a_wp_nack: assert property (@(posedge scl) disable iff (rst)
    data_slot && ack_clk && wp && $past(wp, 3) |-> sda_oe_n) else $error("wp data acked");
  c_read: cover property (@(posedge scl) rw && b == 2'h3 && ack_clk);
  c_wp: cover property (@(posedge scl) data_slot && ack_clk && wp);
  c_lock: cover property (@(posedge clk_sys) serial_lock_bit);
endmodule

bind i2cnv_slave i2cnv_slave_monitor #(.MEM_SLV(MEM_SLV), .CTL_SLV(CTL_SLV))
  i_i2cnv_slave_monitor (.clk_sys(clk_sys), .rst(rst), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wp(wp), .ctl_status(ctl_status),
  .serial_lock_bit(serial_lock_bit));

//--- sim/i2cnv_master.sv
`timescale 1ns/100ps
// Bus master model; SCL stands high between frames, SDA is pulled low or released
module i2cnv_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // START or repeated START: SDA falls while SCL is high
  task automatic start();
    sda_low = 1'b0;
    #16 scl = 1'b1;
    #16 sda_low = 1'b1;
    #16 scl = 1'b0;
  endtask
  // STOP: SDA rises while SCL is high, bus left idle
  task automatic stop();
    #16 sda_low = 1'b1;
    #16 scl = 1'b1;
    #16 sda_low = 1'b0;
    #16;
  endtask
  // One 64 ns SCL pulse; set up mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #16 sda_low = ~b;
    #16 scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
  endtask
  // Top n bits of d; fewer than eight leaves the byte unfinished for an abort
  task automatic send(input logic [7:0] d, input int n, output logic ack);
    logic r;
    for (int i = 7; i > 7 - n; i--) bit_io(d[i], r);
    if (n == 8) bit_io(1'b1, r);
    ack = ~r;
  endtask
  // One byte in; a NACK ends the read
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask
endmodule

//--- sim/i2cnv_slave_tb.sv
`timescale 1ns/100ps
`include "i2cnv_regs.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s: expected %h, seen %h", n, e, s); end end
// Control map first, then rows, then the awkward cases by hand
module i2cnv_slave_tb;
  localparam logic [6:0] MEM = 7'h50; // Arbitrary value
  localparam logic [6:0] CTL = 7'h18; // Arbitrary value
  localparam logic [31:0] ID = 32'h1234_5678; // Arbitrary value
  // Address high byte, with junk upper bits in the first two rows, address low byte, data
  localparam logic [23:0] ROWS [4] = '{24'hE0_10A5, 24'hF2_343C, 24'h1F_FF81, 24'h00_005A};
  logic clk_sys, rst, wp, a;
  logic [7:0] d;
  int failures, n_tests;
  wire scl, m_low, sda_out, sda_oe_n, lock;
  wire [7:0] ctl_status;
  wire sda = ~m_low & (sda_oe_n | sda_out);
  i2cnv_slave #(.MEM_SLV(MEM), .CTL_SLV(CTL), .DEV_ID(ID)) i_i2cnv_slave (.clk_sys(clk_sys),
    .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wp(wp),
    .ctl_status(ctl_status), .serial_lock_bit(lock));
  i2cnv_master i_i2cnv_master (.scl(scl), .sda_low(m_low), .sda(sda));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic wr(input logic [7:0] v, input logic e, input string n);
    i_i2cnv_master.send(v, 8, a);
    `CHK(n, e, a)
  endtask
  task automatic rd(input logic more, input logic [7:0] e, input string n);
    i_i2cnv_master.recv(more, d);
    `CHK(n, e, d)
  endtask
  // Slave byte after a START; own addresses are always answered
  task automatic head(input logic [6:0] s, input logic r);
    i_i2cnv_master.start();
    wr({s, r}, 1'b1, "slave");
  endtask
  task automatic mem_at(input logic [15:0] ad, input logic r);
    head(MEM, 1'b0);
    wr(ad[15:8], 1'b1, "hi");
    wr(ad[7:0], 1'b1, "lo");
    if (r) head(MEM, 1'b1);
  endtask
  task automatic ctl_at(input logic [7:0] ad, input logic r, input logic e);
    head(CTL, 1'b0);
    wr(ad, e, "ctl addr");
    if (r) head(CTL, 1'b1);
  endtask
  task automatic ctl_set(input logic [7:0] v);
    ctl_at(8'h00, 1'b0, 1'b1);
    wr(v, 1'b1, "memctl");
    i_i2cnv_master.stop();
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    failures = 0;
    n_tests = 0;
    repeat (20) @(posedge clk_sys);
    #2 rst = 1'b0;
    // Whole readable control map in one burst, wrapping back to zero
    `CHK("status", 8'h00, ctl_status)
    ctl_at(`I2CNV_CTL_SN_FIRST, 1'b1, 1'b1);
    for (int i = 1; i < 14; i++)
      rd(i < 13, i < 9 ? 8'h00 : i < 13 ? ID[8*(12-i) +: 8] : 8'h00, "map");
    i_i2cnv_master.stop();
    $display("map done");
    foreach (ROWS[j]) begin
      mem_at(ROWS[j][23:8], 1'b0);
      wr(ROWS[j][7:0], 1'b1, "wdata");
      mem_at({3'h0, ROWS[j][20:8]}, 1'b1);
      rd(1'b0, ROWS[j][7:0], "rdata");
      i_i2cnv_master.stop();
    end
    $display("rows done");
    // Burst over the top of memory, then a current read after the wrap
    mem_at(16'h1FFF, 1'b0);
    wr(8'hE1, 1'b1, "w top");
    wr(8'hE2, 1'b1, "w wrap");
    mem_at(16'h1FFF, 1'b1);
    rd(1'b0, 8'hE1, "r top");
    i_i2cnv_master.stop();
    head(MEM, 1'b1);
    rd(1'b0, 8'hE2, "r wrap");
    i_i2cnv_master.stop();
    $display("wrap done");
    // Abort, protected block, then the pin: 0x0010 keeps its value throughout
    mem_at(16'h0010, 1'b0);
    // Stop lands on the seventh clock; a later clock would carry the eighth bit
    i_i2cnv_master.send(8'h11, 6, a);
    i_i2cnv_master.stop();
    ctl_set(8'h0C);
    mem_at(16'h0010, 1'b0);
    wr(8'h22, 1'b0, "prot");
    wr(8'h33, 1'b0, "ignored");
    head(MEM, 1'b1);
    rd(1'b0, 8'hA5, "prot hold");
    i_i2cnv_master.stop();
    // Half protect covers 0x1000, quarter protect only from 0x1800 up
    ctl_set(8'h08);
    mem_at(16'h1000, 1'b0);
    wr(8'h66, 1'b0, "half");
    i_i2cnv_master.stop();
    ctl_set(8'h04);
    mem_at(16'h1000, 1'b0);
    wr(8'h66, 1'b1, "quarter open");
    mem_at(16'h1800, 1'b0);
    wr(8'h77, 1'b0, "quarter top");
    i_i2cnv_master.stop();
    ctl_set(8'h00);
    @(posedge clk_sys);
    #2 wp = 1'b1;
    mem_at(16'h0010, 1'b0);
    wr(8'h44, 1'b0, "wp");
    ctl_at(8'h00, 1'b0, 1'b1);
    wr(8'h01, 1'b0, "wp ctl");
    i_i2cnv_master.stop();
    @(posedge clk_sys);
    #2 wp = 1'b0;
    mem_at(16'h0010, 1'b1);
    rd(1'b0, 8'hA5, "wp hold");
    i_i2cnv_master.stop();
    $display("protect done");
    // Serial burst runs into the read-only identity bytes
    ctl_at(`I2CNV_CTL_SN_FIRST, 1'b0, 1'b1);
    for (int i = 1; i < 9; i++) wr(8'(i) * 8'h11, 1'b1, "serial");
    wr(8'h99, 1'b0, "read only");
    head(CTL, 1'b1);
    rd(1'b0, ID[31:24], "after nack");
    i_i2cnv_master.stop();
    $display("serial done");
    // Lock, then a serial byte refuses data but keeps the counter
    ctl_set(8'h01);
    for (int i = 0; i < 20 && lock !== 1'b1; i++) @(posedge clk_sys);
    `CHK("status", 8'h01, ctl_status)
    `CHK("lock", 1'b1, lock)
    if (lock !== 1'b1) finish_test();
    ctl_at(8'h03, 1'b0, 1'b1);
    wr(8'h5B, 1'b0, "locked");
    head(CTL, 1'b1);
    rd(1'b0, 8'h33, "locked hold");
    i_i2cnv_master.stop();
    ctl_set(8'h00);
    $display("lock done");
    // Unknown command, reads from the command location, an address past the map
    ctl_at(`I2CNV_CTL_CMD, 1'b0, 1'b1);
    wr(8'h5A, 1'b1, "command");
    head(CTL, 1'b1);
    rd(1'b0, 8'h00, "after cmd");
    ctl_at(`I2CNV_CTL_CMD, 1'b1, 1'b1);
    rd(1'b1, 8'h00, "cmd wrap");
    rd(1'b0, 8'h11, "cmd next");
    ctl_at(8'h0D, 1'b0, 1'b0);
    head(CTL, 1'b1);
    rd(1'b0, 8'h22, "oob hold");
    i_i2cnv_master.stop();
    // Another device's address is left unanswered
    i_i2cnv_master.start();
    wr({7'h2B, 1'b0}, 1'b0, "foreign");
    i_i2cnv_master.stop();
    $display("command done");
    finish_test();
  end
endmodule
